// file: cdb_dead_band.sv
// Our own choices: register access over AHB-Lite and the address map.
`default_nettype none
module cdb_dead_band (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        poweron_resetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        count_tick,
   input  wire logic        wave_in,
   output logic             out_a,
   output logic             out_b
);
   typedef struct packed {
      logic        wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic        a;
      logic        b;
      logic        tick_d;
   } cdb_state_t;

   // Count registers live apart: bus writes load them and, of the resets, only power-on reset may touch them
   logic [5:0] rise_delay_count;
   logic [5:0] fall_delay_count;
   logic [5:0] next_rise;
   logic [5:0] next_fall;

   cdb_state_t state;
   cdb_state_t next_state;

   logic a_raw;
   logic b_raw;
   logic rise_busy;
   logic fall_busy;
   logic addr_ok;
   logic [31:0] rd_word;

   // Output A turns on rise_delay ticks after input rises and B went off
   cdb_delay u_rise (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (state.tick_d),
      .level_in  (wave_in),
      .count     (rise_delay_count),
      .level_out (a_raw),
      .busy      (rise_busy)
   );

   // Output B turns on fall_delay ticks after input falls and A went off
   cdb_delay u_fall (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (state.tick_d),
      .level_in  (!wave_in),
      .count     (fall_delay_count),
      .level_out (b_raw),
      .busy      (fall_busy)
   );

   assign addr_ok = hsel && hready && (htrans == cdb_pkg::HTRANS_NONSEQ || htrans == cdb_pkg::HTRANS_SEQ);

   always_comb begin
      rd_word = '0;
      unique case (haddr)
         cdb_pkg::RISE_OFFSET: rd_word[cdb_pkg::COUNT_WIDTH-1:0] = rise_delay_count;
         cdb_pkg::FALL_OFFSET: rd_word[cdb_pkg::COUNT_WIDTH-1:0] = fall_delay_count;
         cdb_pkg::STATUS_OFFSET: begin
            rd_word[cdb_pkg::ST_IN_BIT]        = wave_in;
            rd_word[cdb_pkg::ST_A_BIT]         = state.a;
            rd_word[cdb_pkg::ST_B_BIT]         = state.b;
            rd_word[cdb_pkg::ST_RISE_BUSY_BIT] = rise_busy;
            rd_word[cdb_pkg::ST_FALL_BUSY_BIT] = fall_busy;
         end
         default: rd_word = '0;
      endcase
   end

   always_comb begin
      next_state        = state;
      next_rise         = rise_delay_count;
      next_fall         = fall_delay_count;
      next_state.tick_d = count_tick;
      // Each output held low while the other delay's raw output is high; never both high
      next_state.a      = a_raw && !b_raw;
      next_state.b      = b_raw && !a_raw;
      if (state.wr_pend) begin
         if (state.wr_addr == cdb_pkg::RISE_OFFSET) begin
            next_rise = hwdata[cdb_pkg::COUNT_WIDTH-1:0];
         end
         if (state.wr_addr == cdb_pkg::FALL_OFFSET) begin
            next_fall = hwdata[cdb_pkg::COUNT_WIDTH-1:0];
         end
      end
      next_state.wr_pend = addr_ok && hwrite;
      next_state.wr_addr = haddr;
      if (addr_ok && !hwrite) begin
         next_state.rdata = rd_word;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Counts survive bus reset; only power-on/brown-out reset clears them
   always_ff @(posedge hclk or negedge poweron_resetn) begin
      if (!poweron_resetn) begin
         rise_delay_count <= cdb_pkg::COUNT_POWERON;
         fall_delay_count <= cdb_pkg::COUNT_POWERON;
      end else begin
         rise_delay_count <= next_rise;
         fall_delay_count <= next_fall;
      end
   end

   // Delay start is asynchronous to the tick phase, giving N to N+1 ticks
   assign out_a     = state.a;
   assign out_b     = state.b;
   assign hrdata    = state.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
endmodule
`default_nettype wire

// file: cdb_pkg.sv
`default_nettype none
package cdb_pkg;
   // Register byte offsets on the bus
   localparam logic [11:0] RISE_OFFSET      = 12'h000;
   localparam logic [11:0] FALL_OFFSET      = 12'h004;
   localparam logic [11:0] STATUS_OFFSET    = 12'h008;
   localparam logic [11:0] RESET_OFFSET     = 12'h00C;
   localparam int          COUNT_WIDTH      = 6;
   localparam int          REG_WIDTH        = 8;
   localparam logic [5:0]  COUNT_ZERO       = 6'h00;
   localparam logic [5:0]  COUNT_ONE        = 6'h01;
   // Power-on value of the count fields; the hardware value is undefined
   localparam logic [5:0]  COUNT_POWERON    = 6'h00;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
   localparam logic [2:0]  HSIZE_WORD       = 3'h2;
   // Status word field positions
   localparam int          ST_IN_BIT        = 0;
   localparam int          ST_A_BIT         = 1;
   localparam int          ST_B_BIT         = 2;
   localparam int          ST_RISE_BUSY_BIT = 3;
   localparam int          ST_FALL_BUSY_BIT = 4;
   localparam logic [0:0]  RESET_KEY_BIT    = 1'h1;
endpackage
`default_nettype wire

// file: cdb_delay.sv
`default_nettype none
// One edge delay: output follows a rising input after count ticks
module cdb_delay (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick,
   input  wire logic       level_in,
   input  wire logic [5:0] count,
   output logic            level_out,
   output logic            busy
);
   typedef struct packed {
      logic       out;
      logic       run;
      logic [5:0] left;
   } cdb_dly_t;

   cdb_dly_t state;
   cdb_dly_t next_state;

   always_comb begin
      next_state = state;
      if (!level_in) begin
         next_state.out  = 1'b0;
         next_state.run  = 1'b0;
         next_state.left = cdb_pkg::COUNT_ZERO;
      end else if (!state.out && !state.run) begin
         if (count == cdb_pkg::COUNT_ZERO) begin
            next_state.out = 1'b1;
         end else begin
            next_state.run  = 1'b1;
            next_state.left = count;
         end
      end else if (state.run && tick) begin
         // One extra tick: the first tick may land at once, so N+1 ticks give N to N+1 periods
         if (state.left == cdb_pkg::COUNT_ZERO) begin
            next_state.run = 1'b0;
            next_state.out = 1'b1;
         end else begin
            next_state.left = state.left - cdb_pkg::COUNT_ONE;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level_out = state.out;
   assign busy      = state.run;
endmodule
`default_nettype wire

// file: cdb_bridge_model.sv
`default_nettype none
module cdb_bridge_model (
   input  wire logic hclk,
   input  wire logic high_on,
   input  wire logic low_on,
   output var logic  shorted
);
   timeunit 1ns;
   timeprecision 1ns;
   // A real bridge shorts the supply if both switches conduct at once
   initial shorted = 1'b0;
   always @(posedge hclk) begin
      if (high_on && low_on) begin
         shorted <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: cdb_dead_band_monitor.sv
`default_nettype none
module cdb_dead_band_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic        hready,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        wave_in,
   input wire logic        out_a,
   input wire logic        out_b
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rise; $rose(wave_in); endsequence
   sequence s_fall; $fell(wave_in); endsequence
   property p_okay; hreadyout && !hresp; endproperty
   property p_upper; hrdata[31:6] == 26'h0; endproperty
   property p_apart; !(out_a && out_b); endproperty
   property p_a_on; $rose(out_a) |-> $past(wave_in); endproperty
   property p_b_on; $rose(out_b) |-> !$past(wave_in); endproperty
   property p_b_off; s_rise |-> ##[1:2] !out_b; endproperty
   property p_a_off; s_fall |-> ##[1:2] !out_a; endproperty
   property p_hold; !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata); endproperty
   a_okay: assert property (p_okay) else $error("bus answer wrong");
   a_upper: assert property (p_upper) else $error("upper bits set");
   a_apart: assert property (p_apart) else $error("outputs overlap");
   a_a_on: assert property (p_a_on) else $error("out_a early");
   a_b_on: assert property (p_b_on) else $error("out_b early");
   a_b_off: assert property (p_b_off) else $error("out_b late off");
   a_a_off: assert property (p_a_off) else $error("out_a late off");
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind cdb_dead_band cdb_dead_band_monitor i_cdb_dead_band_monitor (.hclk, .hresetn, .hsel, .hready, .htrans,
   .hwrite, .hrdata, .hreadyout, .hresp, .wave_in, .out_a, .out_b);
`default_nettype wire

// file: cdb_dead_band_tb_top.sv
`default_nettype none
module cdb_dead_band_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 4;
   logic        hclk = 0, hresetn = 0, poweron_resetn = 0, hsel = 0, hwrite = 0, count_tick = 0, wave_in = 0;
   logic [11:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic [31:0] hwdata = '0, hrdata;
   logic        hreadyout, hresp, out_a, out_b, shorted;
   int          bad_count = 0, comparisons = 0, cyc = 0, t;
   always #25 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      count_tick <= (cyc % P == 0);
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   cdb_dead_band i_cdb_dead_band (.hclk, .hresetn, .poweron_resetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(cdb_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .count_tick,
      .wave_in, .out_a, .out_b);
   cdb_bridge_model i_cdb_bridge_model (.hclk, .high_on(out_a), .low_on(out_b), .shorted);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= cdb_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      if (!wr) chk(hrdata, exp);
   endtask
   // Window is loose by one tick and the output pipeline, since ticks run free
   task automatic edge_delay(input logic lvl, input int cnt);
      wave_in <= lvl;
      t = 0;
      while ((lvl ? out_a : out_b) !== 1'b1 && t < 400) begin
         @(posedge hclk);
         t++;
      end
      chk(32'(cnt == 0 ? t <= 3 : t >= cnt * P && t <= (cnt + 1) * P + 3), 32'h1);
      repeat (4) @(posedge hclk);
   endtask
   task automatic wrap_up();
      $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      poweron_resetn <= 1'b1;
      xfer(0, cdb_pkg::RISE_OFFSET, 0, 32'h0000_0000);
      xfer(0, cdb_pkg::RESET_OFFSET, 0, 32'h0000_0000);
      xfer(1, cdb_pkg::RISE_OFFSET, 32'hFFFF_FFFF, 0);
      xfer(0, cdb_pkg::RISE_OFFSET, 0, 32'h0000_003F);
      xfer(1, cdb_pkg::FALL_OFFSET, 32'h0000_00EA, 0);
      xfer(0, cdb_pkg::FALL_OFFSET, 0, 32'h0000_002A);
      $display("test registers done");
      for (int n = 0; n < 64; n = n * 62 + 1) begin
         xfer(1, cdb_pkg::RISE_OFFSET, 32'(n), 0);
         xfer(1, cdb_pkg::FALL_OFFSET, 32'(n), 0);
         edge_delay(1'b1, n);
         xfer(0, cdb_pkg::STATUS_OFFSET, 0, 32'h0000_0003);
         edge_delay(1'b0, n);
         xfer(0, cdb_pkg::STATUS_OFFSET, 0, 32'h0000_0004);
         $display("test delay %0d done", n);
      end
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, cdb_pkg::FALL_OFFSET, 0, 32'h0000_003F);
      poweron_resetn <= 1'b0;
      repeat (2) @(posedge hclk);
      poweron_resetn <= 1'b1;
      xfer(0, cdb_pkg::RISE_OFFSET, 0, 32'(cdb_pkg::COUNT_POWERON));
      chk(32'(shorted), 32'h0);
      $display("test resets done");
      wrap_up();
   end
endmodule
`default_nettype wire
